// [verilog/msa_cfg.svh]
// addresses, field positions, reset values and step counts for the result-register block
`ifndef MSA_CFG_SVH
`define MSA_CFG_SVH
// byte addresses of the eight result bytes and the two control bytes
`define MSA_ADDR_RA_HI 32'hFFFF8420
`define MSA_ADDR_RA_LO 32'hFFFF8421
`define MSA_ADDR_RB_HI 32'hFFFF8422
`define MSA_ADDR_RB_LO 32'hFFFF8423
`define MSA_ADDR_RC_HI 32'hFFFF8424
`define MSA_ADDR_RC_LO 32'hFFFF8425
`define MSA_ADDR_RD_HI 32'hFFFF8426
`define MSA_ADDR_RD_LO 32'hFFFF8427
`define MSA_ADDR_CSR 32'hFFFF8428
`define MSA_ADDR_TRG 32'hFFFF8429
// control/status bit positions
`define MSA_CSR_FLAG 7
`define MSA_CSR_IE 6
`define MSA_CSR_START 5
`define MSA_CSR_SCAN 4
`define MSA_CSR_SPEED 3
`define MSA_CSR_RST 8'h00
// trigger control: enable in bit 7, reserved bits read one
`define MSA_TRG_EN 7
`define MSA_TRG_RSVD 7'h7F
`define MSA_TRG_EN_RST 1'b0
// result layout
`define MSA_RES_W 10
`define MSA_RES_RST 10'h000
`define MSA_LO_PAD 6'h00
// clocks per approximation step, minus one (slow and fast speed)
`define MSA_STEP_SLOW 8'h17
`define MSA_STEP_FAST 8'h0B
// index of the sampling phase, above the top result bit
`define MSA_SAMPLE_IDX 4'hA
`endif

// [verilog/msa_pkg.sv]
// types shared by the result-register block
`default_nettype none
package msa_pkg;
   // sequencer states, one-hot
   typedef enum logic [1:0]
   {
      MSA_ST_IDLE = 2'b01,
      MSA_ST_RUN = 2'b10
   } msa_state_t;
   // one converted value
   typedef logic [9:0] msa_res_t;
endpackage
`default_nettype wire

// [verilog/msa_sar.sv]
// successive-approximation sequencer: sampling phase then ten trial bits
`default_nettype none
`include "msa_cfg.svh"
module msa_sar
(
   input wire logic clk, // system clock
   input wire logic arst_n, // async reset, low
   input wire logic start, // one-cycle launch
   input wire logic abort, // drop a running conversion
   input wire logic speed_fast, // shorter step period
   input wire logic cmp_hi, // input above trial code, synced
   output var logic busy, // conversion running
   output var logic sample_q, // sample-and-hold closed
   output var logic done, // one-cycle end pulse
   output var msa_pkg::msa_res_t result, // last finished value
   output var msa_pkg::msa_res_t dac_code // trial code to comparator
);
   import msa_pkg::*;
   logic [7:0] div_q; // step divider
   logic step_en; // one-cycle step enable
   logic [3:0] idx_q; // bit under trial
   msa_res_t kept; // trial code after this decision
   msa_res_t next_bit; // next trial bit
   assign step_en = busy && (div_q == 8'h00);
   // step divider, reloaded on launch so the first step is a full period
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         div_q <= 8'h00;
      else if (start || step_en)
         div_q <= speed_fast ? `MSA_STEP_FAST : `MSA_STEP_SLOW;
      else if (busy)
         div_q <= div_q - 8'h01;
   end
   // decide the current bit from the comparator
   always_comb
   begin
      kept = dac_code;
      if (!cmp_hi && idx_q < `MSA_SAMPLE_IDX)
         kept[idx_q] = 1'b0;
      next_bit = (idx_q == 4'h0) ? 10'h000 : (10'h200 >> (4'hA - idx_q));
   end
   // bit sequencing; abort wins over a step in the same cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy <= 1'b0;
         sample_q <= 1'b0;
         done <= 1'b0;
         idx_q <= 4'h0;
         dac_code <= `MSA_RES_RST;
         result <= `MSA_RES_RST;
      end
      else
      begin
         done <= 1'b0;
         if (abort)
         begin
            busy <= 1'b0;
            sample_q <= 1'b0;
         end
         else if (start)
         begin
            busy <= 1'b1;
            sample_q <= 1'b1;
            idx_q <= `MSA_SAMPLE_IDX;
            dac_code <= `MSA_RES_RST;
         end
         else if (step_en)
         begin
            if (sample_q)
            begin
               sample_q <= 1'b0;
               idx_q <= 4'h9;
               dac_code <= 10'h200;
            end
            else if (idx_q == 4'h0)
            begin
               busy <= 1'b0;
               done <= 1'b1;
               result <= kept;
               dac_code <= kept;
            end
            else
            begin
               idx_q <= idx_q - 4'h1;
               dac_code <= kept | next_bit;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/msa_top.sv]
// converter control, result registers and cpu byte interface
`default_nettype none
`include "msa_cfg.svh"
// Functional notes
// - each result is 10 bits, stored per group position
// - top 8 bits high byte, 2 bits low
// - low byte bits 5..0 read zero
// - result registers clear on reset
// - high byte direct, low byte via holding
// - four 16-bit result registers A to D
// - group position picks register A to D
// - inputs 0-3 group 0, 4-7 group 1
// - any of eight inputs selectable
// - single mode and scan of 1-4 inputs
// - completion raises done interrupt when enabled
// - timer trigger can start conversion
// - flag bit accepts only zero writes
// - high read copies low byte to holding
// - flag sets at end of pass, clears read-then-zero
// - single start self-clears, scan repeats
// - channel top bit group, low bits input/count
module msa_top
(
   input wire logic clk, // system clock 125 MHz
   input wire logic arst_n, // power-on reset, low
   input wire logic [31:0] bus_addr, // cpu byte address
   input wire logic bus_rd, // cpu byte read strobe
   input wire logic bus_wr, // cpu byte write strobe
   input wire logic [7:0] bus_wdata, // cpu write byte
   output var logic [7:0] bus_rdata, // read byte, next cycle
   input wire logic timer_trig, // timer unit start pulse
   input wire logic cmp_in, // comparator pin, async
   output var logic [2:0] input_sel, // analog input mux select
   output var logic sample_hold, // sample switch closed
   output var msa_pkg::msa_res_t dac_code, // trial code to comparator
   output var logic conversion_done_irq // done interrupt level
);
   import msa_pkg::*;

   // control/status fields
   logic flag_q; // completion flag
   logic irq_en_q; // done interrupt enable
   logic start_q; // conversion start bit
   logic scan_q; // scan mode
   logic speed_q; // speed select
   logic [2:0] chan_q; // input select field
   logic trg_en_q; // timer start enable
   logic flag_seen_q; // flag was read as one
   // result store and cpu path
   msa_res_t res_q [4]; // result registers A..D
   logic [7:0] hold_q; // low-byte holding register
   // sequencer
   msa_state_t state_q; // idle or converting
   logic [1:0] pos_q; // position within group
   logic launch_q; // start pulse to sequencer
   // comparator synchroniser
   logic cmp_s1_q; // first stage, feeds only s2
   logic cmp_s2_q; // second stage
   logic cmp_s3_q; // third stage
   logic cmp_q; // accepted comparator level
   // sequencer outputs
   logic sar_busy; // conversion in flight
   logic sar_sample; // sampling phase
   logic sar_done; // end pulse
   msa_res_t sar_result; // finished value
   msa_res_t sar_code; // trial code
   // decode
   logic csr_wr; // write to control/status
   logic csr_rd; // read of control/status
   logic trg_wr; // write to trigger control
   logic hi_rd; // read of a result high byte
   logic last_pos; // this position ends the pass
   logic finish; // conversion completes now
   logic pass_end; // all selected inputs done
   logic flag_clr; // legal flag clear now
   logic trig_start; // accepted timer start
   logic abort; // start bit dropped while busy
   logic lo_rd; // read of a result low byte
   // reset image of control/status; a named constant can be bit-selected
   localparam logic [7:0] csr_rst = `MSA_CSR_RST;

   // address decode, exact byte addresses only
   assign csr_wr = bus_wr && (bus_addr == `MSA_ADDR_CSR);
   assign csr_rd = bus_rd && (bus_addr == `MSA_ADDR_CSR);
   assign trg_wr = bus_wr && (bus_addr == `MSA_ADDR_TRG);
   // high bytes sit on the even addresses A..D
   assign hi_rd = bus_rd && (bus_addr[31:3] == 29'(`MSA_ADDR_RA_HI >> 3)) && !bus_addr[0];
   assign lo_rd = bus_rd && (bus_addr[31:3] == 29'(`MSA_ADDR_RA_HI >> 3)) && bus_addr[0];
   // single mode ends every conversion, scan ends at the counted input
   assign last_pos = !scan_q || (pos_q == chan_q[1:0]);
   assign finish = (state_q == MSA_ST_RUN) && sar_done;
   assign pass_end = finish && last_pos;
   // a clear counts only after the flag was seen set
   assign flag_clr = csr_wr && !bus_wdata[`MSA_CSR_FLAG] && flag_seen_q;
   assign trig_start = timer_trig && trg_en_q;
   assign abort = (state_q == MSA_ST_RUN) && !start_q;

   // three-stage sync; a new level counts once stages two and three agree
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
         cmp_s3_q <= 1'b0;
         cmp_q <= 1'b0;
      end
      else
      begin
         cmp_s1_q <= cmp_in;
         cmp_s2_q <= cmp_s1_q;
         cmp_s3_q <= cmp_s2_q;
         // ignore a level still moving through the chain
         if (cmp_s2_q == cmp_s3_q)
            cmp_q <= cmp_s3_q;
      end
   end

   // completion flag: hardware set beats a clear in the same cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_q <= 1'b0;
      else if (pass_end)
         flag_q <= 1'b1;
      else if (flag_clr)
         flag_q <= 1'b0;
      // writing one to the flag has no effect
   end

   // remembers the read that arms a clear; a new set re-arms from scratch
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flag_seen_q <= 1'b0;
      else if (pass_end || flag_clr)
         flag_seen_q <= 1'b0;
      else if (csr_rd && flag_q)
         flag_seen_q <= 1'b1;
   end

   // plain control fields; software should only change them while stopped
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_en_q <= csr_rst[`MSA_CSR_IE];
         scan_q <= csr_rst[`MSA_CSR_SCAN];
         speed_q <= csr_rst[`MSA_CSR_SPEED];
         chan_q <= csr_rst[2:0];
      end
      else if (csr_wr)
      begin
         irq_en_q <= bus_wdata[`MSA_CSR_IE];
         scan_q <= bus_wdata[`MSA_CSR_SCAN];
         speed_q <= bus_wdata[`MSA_CSR_SPEED];
         chan_q <= bus_wdata[2:0];
      end
   end

   // start bit: software or timer sets it, single completion clears it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         start_q <= csr_rst[`MSA_CSR_START];
      else if (csr_wr)
         start_q <= bus_wdata[`MSA_CSR_START] || trig_start;
      else if (trig_start)
         start_q <= 1'b1;
      else if (finish && !scan_q)
         start_q <= 1'b0;
   end

   // timer start enable; the reserved bits are constants
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         trg_en_q <= `MSA_TRG_EN_RST;
      else if (trg_wr)
         trg_en_q <= bus_wdata[`MSA_TRG_EN];
   end

   // sequencer: launch, step through the group, repeat in scan
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= MSA_ST_IDLE;
         pos_q <= 2'h0;
         launch_q <= 1'b0;
      end
      else
      begin
         launch_q <= 1'b0;
         case (state_q)
            MSA_ST_IDLE:
            begin
               // scan always begins at the group's first input
               if (start_q)
               begin
                  state_q <= MSA_ST_RUN;
                  pos_q <= scan_q ? 2'h0 : chan_q[1:0];
                  launch_q <= 1'b1;
               end
            end
            MSA_ST_RUN:
            begin
               if (abort)
                  state_q <= MSA_ST_IDLE;
               else if (finish)
               begin
                  if (!scan_q)
                     state_q <= MSA_ST_IDLE;
                  else
                  begin
                     // next input of the group, wrapping to the first after the last
                     pos_q <= last_pos ? 2'h0 : pos_q + 2'h1;
                     launch_q <= 1'b1;
                  end
               end
            end
            default:
               state_q <= MSA_ST_IDLE;
         endcase
      end
   end

   // result store: written only by a completed conversion, never by the cpu
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 4; i++)
            res_q[i] <= `MSA_RES_RST;
      end
      else if (finish)
         res_q[pos_q] <= sar_result;
   end

   // holding register: a high-byte read freezes the matching low byte
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         hold_q <= 8'h00;
      else if (hi_rd)
         hold_q <= {res_q[bus_addr[2:1]][1:0], `MSA_LO_PAD};
   end

   // read data; a lone low-byte read returns stale holding contents
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         bus_rdata <= 8'h00;
      else if (bus_rd)
      begin
         case (bus_addr)
            `MSA_ADDR_RA_HI, `MSA_ADDR_RB_HI, `MSA_ADDR_RC_HI, `MSA_ADDR_RD_HI:
               bus_rdata <= res_q[bus_addr[2:1]][9:2];
            `MSA_ADDR_RA_LO, `MSA_ADDR_RB_LO, `MSA_ADDR_RC_LO, `MSA_ADDR_RD_LO:
               bus_rdata <= hold_q;
            `MSA_ADDR_CSR:
               bus_rdata <= {flag_q, irq_en_q, start_q, scan_q, speed_q, chan_q};
            `MSA_ADDR_TRG:
               bus_rdata <= {trg_en_q, `MSA_TRG_RSVD};
            default:
               bus_rdata <= 8'h00; // unmapped reads as zero
         endcase
      end
   end

   // pin-facing outputs, registered; group bit on top of the position
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         input_sel <= 3'h0;
         sample_hold <= 1'b0;
         dac_code <= `MSA_RES_RST;
         conversion_done_irq <= 1'b0;
      end
      else
      begin
         input_sel <= {chan_q[2], pos_q};
         sample_hold <= sar_sample;
         dac_code <= sar_code;
         conversion_done_irq <= flag_q && irq_en_q;
      end
   end

   // bit sequencer
   msa_sar u_sar
   (
      .clk(clk),
      .arst_n(arst_n),
      .start(launch_q),
      .abort(abort),
      .speed_fast(speed_q),
      .cmp_hi(cmp_q),
      .busy(sar_busy),
      .sample_q(sar_sample),
      .done(sar_done),
      .result(sar_result),
      .dac_code(sar_code)
   );

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   result_store_a: assert property (finish |=> res_q[$past(pos_q)] == $past(sar_result))
      else $error("result not stored on completion");
   result_hold_a: assert property (!finish |=> $stable(res_q[0]) && $stable(res_q[1])
      && $stable(res_q[2]) && $stable(res_q[3]))
      else $error("result changed without completion");
   hold_layout_a: assert property (hi_rd |=> hold_q == {$past(res_q[bus_addr[2:1]][1:0]), 6'h00})
      else $error("holding register not loaded by high read");
   hi_read_a: assert property (hi_rd |=> bus_rdata == $past(res_q[bus_addr[2:1]][9:2]))
      else $error("high byte not returned directly");
   lo_read_a: assert property (lo_rd |=> bus_rdata == $past(hold_q))
      else $error("low byte not returned from holding");
   hold_pad_a: assert property (hold_q[5:0] == 6'h00)
      else $error("reserved low bits not zero");
   flag_set_a: assert property (pass_end |=> flag_q && res_q[$past(pos_q)] == $past(sar_result))
      else $error("flag set without result");
   flag_one_a: assert property (csr_wr && bus_wdata[7] && !flag_q && !pass_end |=> !flag_q)
      else $error("write of one set the flag");
   flag_clear_a: assert property (flag_clr && !pass_end |=> !flag_q)
      else $error("legal clear did not clear flag");
   single_stop_a: assert property (finish && !scan_q && !csr_wr && !trig_start |=> !start_q)
      else $error("single start bit did not clear");
   scan_go_a: assert property (finish && scan_q && !abort |=> launch_q ##1 (sar_busy || $past(abort)))
      else $error("scan did not continue");
   trig_a: assert property (trig_start |=> start_q)
      else $error("timer start missed");
   irq_a: assert property (1'b1 |=> conversion_done_irq == $past(flag_q && irq_en_q))
      else $error("done interrupt not raised");
   select_a: assert property (state_q == MSA_ST_RUN |=> input_sel[2] == $past(chan_q[2]))
      else $error("wrong input group");
   scan_abort_a: assert property (abort |=> state_q == MSA_ST_IDLE && !sar_busy)
      else $error("cleared start bit did not stop conversion");

   single_c: cover property (finish && !scan_q);
   scan_wrap_c: cover property (pass_end && scan_q && chan_q[1:0] == 2'h3);
   read_pair_c: cover property (hi_rd ##2 lo_rd);
   clear_c: cover property (flag_clr);
   abort_c: cover property (abort);
endmodule
`default_nettype wire

// [tb/msa_analog_model.sv]
// analog side stand-in: eight fixed input levels feeding the comparator
`default_nettype none
module msa_analog_model
(
   input wire logic [79:0] levels, // eight 10-bit levels, input 0 lowest
   input wire logic [2:0] input_sel, // mux select from the block
   input wire msa_pkg::msa_res_t dac_code, // trial code from the block
   output var logic cmp_in // high when input is above trial code
);
   timeunit 1ns;
   timeprecision 1ps;
   import msa_pkg::*;
   logic [9:0] level_sel; // level on the selected input
   // the mux follows the select at once, as the analog switch would
   assign level_sel = levels[input_sel*10 +: 10];
   // each level sits half a step above its code, so a tie reads as above
   // and the search settles exactly on the level itself
   assign cmp_in = (level_sel >= dac_code);
endmodule
`default_nettype wire

// [tb/msa_top_tb.sv]
// self-checking bench for the converter result-register block
`default_nettype none
`include "msa_cfg.svh"
module msa_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import msa_pkg::*;
   logic clk; // 125 MHz system clock
   logic arst_n; // async reset, low
   logic [31:0] bus_addr; // cpu byte address
   logic bus_rd; // read strobe
   logic bus_wr; // write strobe
   logic [7:0] bus_wdata; // write byte
   logic [7:0] bus_rdata; // read byte
   logic timer_trig; // timer start pulse
   logic cmp_in; // comparator from analog model
   logic [2:0] input_sel; // mux select
   logic sample_hold; // sampling phase
   msa_res_t dac_code; // trial code
   logic conversion_done_irq; // done interrupt
   logic [79:0] levels; // analog levels, input 0 lowest
   int err_total; // mismatches seen
   int samples_checked; // comparisons made
   logic [15:0] v; // scratch read value
   // free-running clock, 8 ns period
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   msa_top dut_u
   (
      .clk(clk),
      .arst_n(arst_n),
      .bus_addr(bus_addr),
      .bus_rd(bus_rd),
      .bus_wr(bus_wr),
      .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata),
      .timer_trig(timer_trig),
      .cmp_in(cmp_in),
      .input_sel(input_sel),
      .sample_hold(sample_hold),
      .dac_code(dac_code),
      .conversion_done_irq(conversion_done_irq)
   );
   msa_analog_model ana_u
   (
      .levels(levels),
      .input_sel(input_sel),
      .dac_code(dac_code),
      .cmp_in(cmp_in)
   );
   // expected code of one input, straight from the level table
   function automatic logic [9:0] lvl(input int i);
      return levels[i*10 +: 10];
   endfunction
   // compare and count; bytes arrive zero-extended
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask
   // final counts and verdict
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one-cycle write strobe, taken at the edge where it is high
   task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   // one-cycle read strobe; data is registered, so sample a cycle later
   task automatic bus_read(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      d = {8'h00, bus_rdata};
   endtask
   // high byte first so the low byte lands in the holding register
   task automatic read_res(input int idx, output logic [15:0] r);
      logic [15:0] hi;
      logic [15:0] lo;
      bus_read(32'(`MSA_ADDR_RA_HI + 2 * idx), hi);
      bus_read(32'(`MSA_ADDR_RA_HI + 2 * idx + 1), lo);
      r = {hi[7:0], lo[7:0]};
   endtask
   // bounded wait for the done interrupt; a hang ends the run
   task automatic wait_irq();
      int n;
      n = 0;
      while (conversion_done_irq !== 1'b1)
      begin
         @(negedge clk);
         n++;
         if (n > 2000)
         begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
            err_total++;
            close_out();
         end
      end
   endtask
   // every result byte, both control bytes and a hole after reset
   task automatic t_reset_vals();
      for (int i = 0; i < 8; i++)
      begin
         bus_read(32'(`MSA_ADDR_RA_HI + i), v);
         check(v, 16'h0000);
      end
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h0000);
      bus_read(`MSA_ADDR_TRG, v);
      check(v, 16'h007F);
      bus_read(32'hFFFF842A, v);
      check(v, 16'h0000);
   endtask
   // timer pulse with the trigger disabled must not start anything
   task automatic t_trig_off();
      @(posedge clk);
      timer_trig <= 1'b1;
      @(posedge clk);
      timer_trig <= 1'b0;
      repeat (4) @(posedge clk);
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h0000);
      check({15'h0000, sample_hold}, 16'h0000);
   endtask
   // single conversion of input 5, fast speed, interrupt on
   task automatic t_single();
      bus_write(`MSA_ADDR_CSR, 8'h6D);
      repeat (10) @(posedge clk);
      @(negedge clk);
      check({13'h0000, input_sel}, 16'h0005);
      check({15'h0000, sample_hold}, 16'h0001);
      wait_irq();
      check({6'h00, dac_code}, {6'h00, lvl(5)});
      read_res(1, v);
      check(v, {lvl(5), 6'h00});
      // zero written to the flag before it was read must not clear it
      bus_write(`MSA_ADDR_CSR, 8'h40);
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h00C0);
   endtask
   // a one to the flag is ignored; zero after a read clears it
   task automatic t_flag_clear();
      bus_write(`MSA_ADDR_CSR, 8'hC0);
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h00C0);
      bus_write(`MSA_ADDR_CSR, 8'h40);
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h0040);
      check({15'h0000, conversion_done_irq}, 16'h0000);
      bus_write(`MSA_ADDR_CSR, 8'hC0);
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h0040);
   endtask
   // timer-started scan of all of group 0, stopped by software
   task automatic t_scan_timer();
      bus_write(`MSA_ADDR_TRG, 8'h80);
      bus_read(`MSA_ADDR_TRG, v);
      check(v, 16'h00FF);
      bus_write(`MSA_ADDR_CSR, 8'h53);
      @(posedge clk);
      timer_trig <= 1'b1;
      @(posedge clk);
      timer_trig <= 1'b0;
      wait_irq();
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h00F3);
      bus_write(`MSA_ADDR_CSR, 8'h43);
      for (int i = 0; i < 4; i++)
      begin
         read_res(i, v);
         check(v, {lvl(i), 6'h00});
      end
      bus_read(`MSA_ADDR_CSR, v);
      check(v, 16'h0043);
      bus_write(`MSA_ADDR_TRG, 8'h00);
   endtask
   // result bytes refuse bus writes
   task automatic t_ro_results();
      bus_write(`MSA_ADDR_RA_HI, 8'hFF);
      bus_write(`MSA_ADDR_RA_LO, 8'hFF);
      read_res(0, v);
      check(v, {lvl(0), 6'h00});
   endtask
   // reset in mid-conversion brings every register back to its reset value
   task automatic t_mid_reset();
      bus_write(`MSA_ADDR_CSR, 8'h20);
      repeat (40) @(posedge clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      check({6'h00, dac_code}, 16'h0000);
      arst_n <= 1'b1;
      t_reset_vals();
   endtask
   // main sequence: reset for three cycles, then the scenarios in turn
   initial
   begin
      err_total = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      bus_addr = 32'h00000000;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 8'h00;
      timer_trig = 1'b0;
      levels = {10'h300, 10'h0AA, 10'h1C7, 10'h200, 10'h001, 10'h3FF, 10'h155, 10'h2A5};
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_reset_vals();
      t_trig_off();
      t_single();
      t_flag_clear();
      t_scan_timer();
      t_ro_results();
      t_mid_reset();
      close_out();
   end
endmodule
`default_nettype wire
